// ### logic/fsps_pkg.sv
// Package of constants for the flash self programming sequencer
// ----------------------------------------------------------------------------
// Functional notes
// - In self programming mode, HALT starts the loaded flash command, not standby.
// - Completion of the flash command releases HALT without any interrupt.
// - Maskable interrupt servicing is blocked throughout self programming mode.
// - Whole-block internal verify checks one block and takes 6.8 ms.
// - Multi-address internal verify takes 27 us for each verified byte.
// - Block erase erases the preset block number; each erase takes 8.5 ms.
// - Block blank check tests the preset block for erasure in 480 us.
// - Byte write programs one byte at the preset address within 150 us.
// - CPU executes nothing while a command runs; commands use no RAM.
// - Interrupts raised in self programming stay pending until the mode ends.
// - Block erase leaves every byte of the block at ff.
// - After mode entry, NOP then HALT; release within 10 us plus 2 clocks.
// - Programmer security has no effect here; only the protect byte restricts.
// - A protect byte at flash address 0081 names areas not to erase or write.
// - Mode control register takes a write only through the unlock sequence.
// - Mode bit 0: zero is normal with standby HALT, one is self programming.
// - Reset release clears the mode bit and loads protect bits 2 to 6.
// - Unlock: a5 to unlock register, value, inverse, value; last one counts.
// - A broken unlock sets status bit 0; writing 0 clears it.
// ----------------------------------------------------------------------------
`default_nettype none
package fsps_pkg;
   // Register addresses
   localparam logic [15:0] ADDR_UNLOCK = 16'hffa0;
   localparam logic [15:0] ADDR_STATUS = 16'hffa1;
   localparam logic [15:0] ADDR_MODE = 16'hffa2;
   localparam logic [15:0] ADDR_CMD = 16'hffa3;
   localparam logic [15:0] ADDR_PTR_L = 16'hffa4;
   localparam logic [15:0] ADDR_PTR_H = 16'hffa5;
   localparam logic [15:0] ADDR_CMP_L = 16'hffa6;
   localparam logic [15:0] ADDR_CMP_H = 16'hffa7;
   localparam logic [15:0] ADDR_WBUF = 16'hffa8;
   localparam logic [15:0] PROTECT_BYTE_ADDR = 16'h0081;
   localparam logic [7:0] UNLOCK_KEY = 8'ha5;
   localparam logic [7:0] BLANK_VALUE = 8'hff;
   // Field positions
   localparam int MODE_BIT = 0;
   localparam int PROT_LSB = 2;
   localparam int PROT_MSB = 6;
   localparam int ERR_UNLOCK = 0;
   localparam int ERR_VERIFY = 1;
   localparam int ERR_PROTECT = 2;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [2:0] CMD_RST = 3'h0;
   // Commands
   localparam logic [2:0] CMD_VERIFY_BLK = 3'h1;
   localparam logic [2:0] CMD_VERIFY_BYTE = 3'h2;
   localparam logic [2:0] CMD_ERASE = 3'h3;
   localparam logic [2:0] CMD_BLANK = 3'h4;
   localparam logic [2:0] CMD_WRITE = 3'h5;
   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int T_VERIFY_BLK_NS = 6_800_000;
   localparam int T_VERIFY_BYTE_NS = 27_000;
   localparam int T_ERASE_NS = 8_500_000;
   localparam int T_BLANK_NS = 480_000;
   localparam int T_WRITE_NS = 150_000;
   localparam int T_ENTRY_NS = 10_000;
   localparam int ENTRY_EXTRA_CYC = 2;
   localparam int CYC_VERIFY_BLK = T_VERIFY_BLK_NS / (1_000_000_000 / CLK_HZ);
   localparam int CYC_VERIFY_BYTE = T_VERIFY_BYTE_NS / (1_000_000_000 / CLK_HZ);
   localparam int CYC_ERASE = T_ERASE_NS / (1_000_000_000 / CLK_HZ);
   localparam int CYC_BLANK = T_BLANK_NS / (1_000_000_000 / CLK_HZ);
   localparam int CYC_WRITE = T_WRITE_NS / (1_000_000_000 / CLK_HZ);
   localparam int CYC_ENTRY =
      T_ENTRY_NS / (1_000_000_000 / CLK_HZ) + ENTRY_EXTRA_CYC;
   // Sequencer states
   typedef enum logic [1:0] {
      FSPS_IDLE = 2'b00,
      FSPS_RUN = 2'b01,
      FSPS_WAKE = 2'b10
   } fsps_state_e;
   // Unlock tracker states
   typedef enum logic [1:0] {
      ULK_IDLE = 2'b00,
      ULK_KEY = 2'b01,
      ULK_VAL = 2'b10,
      ULK_INV = 2'b11
   } fsps_ulk_e;
endpackage
`default_nettype wire

// ### logic/fsps_sequencer.sv
// Flash self programming sequencer: registers, unlock guard and HALT control
`timescale 1ns/1ps
`default_nettype none
module fsps_sequencer (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_halt,
   input wire logic [4:0] i_protect_byte,
   input wire logic i_flash_verify_ok,
   input wire logic i_flash_blank_ok,
   output logic [7:0] o_rdata,
   output logic o_busy,
   output logic o_wake,
   output logic o_standby,
   output logic o_irq_block,
   output logic o_flash_start,
   output logic [2:0] o_flash_cmd,
   output logic [15:0] o_flash_addr,
   output logic [15:0] o_flash_cmp,
   output logic [7:0] o_flash_data
);
   // ------------------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------------------
   logic mode_ff;
   logic [4:0] prot_ff;
   logic prot_load_ff;
   logic [2:0] status_ff;
   logic [2:0] cmd_ff;
   logic [7:0] ptr_l_ff;
   logic [7:0] ptr_h_ff;
   logic [7:0] cmp_l_ff;
   logic [7:0] cmp_h_ff;
   logic [7:0] wbuf_ff;
   logic [7:0] ulk_val_ff;
   fsps_pkg::fsps_ulk_e ulk_ff;
   fsps_pkg::fsps_state_e st_ff;
   logic entry_pend_ff;
   logic [16:0] load_cyc;
   logic timer_done;
   logic start_op;
   logic ulk_err;
   logic mode_wr_ok;
   logic prot_hit;
   logic [7:0] nxt_rdata;

   // ------------------------------------------------------------------------
   // Unlock guard
   // ------------------------------------------------------------------------
   // Tracks key, value, inverse, value; any other store breaks the chain
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ulk_ff <= fsps_pkg::ULK_IDLE;
         ulk_val_ff <= 8'h0;
      end else if (i_wr) begin
         if (i_addr == fsps_pkg::ADDR_UNLOCK &&
             i_wdata == fsps_pkg::UNLOCK_KEY) begin
            ulk_ff <= fsps_pkg::ULK_KEY;
         end else begin
            unique case (ulk_ff)
               fsps_pkg::ULK_KEY: begin
                  ulk_ff <= (i_addr == fsps_pkg::ADDR_MODE) ?
                            fsps_pkg::ULK_VAL : fsps_pkg::ULK_IDLE;
                  ulk_val_ff <= i_wdata;
               end
               fsps_pkg::ULK_VAL: begin
                  ulk_ff <= (i_addr == fsps_pkg::ADDR_MODE &&
                             i_wdata == ~ulk_val_ff) ?
                            fsps_pkg::ULK_INV : fsps_pkg::ULK_IDLE;
               end
               fsps_pkg::ULK_INV: ulk_ff <= fsps_pkg::ULK_IDLE;
               fsps_pkg::ULK_IDLE: ulk_ff <= fsps_pkg::ULK_IDLE;
            endcase
         end
      end
   end

   // Breaks and the accepted final write
   always_comb begin
      ulk_err = 1'b0;
      mode_wr_ok = 1'b0;
      if (i_wr) begin
         if (i_addr == fsps_pkg::ADDR_UNLOCK) begin
            ulk_err = (i_wdata != fsps_pkg::UNLOCK_KEY) ||
                      (ulk_ff != fsps_pkg::ULK_IDLE);
         end else if (ulk_ff == fsps_pkg::ULK_KEY) begin
            ulk_err = (i_addr != fsps_pkg::ADDR_MODE);
         end else if (ulk_ff == fsps_pkg::ULK_VAL) begin
            ulk_err = (i_addr != fsps_pkg::ADDR_MODE) ||
                      (i_wdata != ~ulk_val_ff);
         end else if (ulk_ff == fsps_pkg::ULK_INV) begin
            ulk_err = (i_addr != fsps_pkg::ADDR_MODE) ||
                      (i_wdata != ulk_val_ff);
            mode_wr_ok = !ulk_err;
         end else if (i_addr == fsps_pkg::ADDR_MODE) begin
            ulk_err = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Mode control register
   // ------------------------------------------------------------------------
   // Mode bit changes only through the guarded final write
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         mode_ff <= 1'b0;
      end else if (mode_wr_ok && st_ff == fsps_pkg::FSPS_IDLE) begin
         mode_ff <= i_wdata[fsps_pkg::MODE_BIT];
      end
   end

   // Protect setting captured once after reset release
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         prot_ff <= 5'h0;
         prot_load_ff <= 1'b1;
      end else if (prot_load_ff) begin
         prot_ff <= i_protect_byte;
         prot_load_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------------------
   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         status_ff <= fsps_pkg::STATUS_RST[2:0];
      end else begin
         if (i_wr && i_addr == fsps_pkg::ADDR_STATUS) begin
            status_ff <= status_ff & i_wdata[2:0];
         end
         if (ulk_err) begin
            status_ff[fsps_pkg::ERR_UNLOCK] <= 1'b1;
         end
         if (start_op && prot_hit) begin
            status_ff[fsps_pkg::ERR_PROTECT] <= 1'b1;
         end
         if (timer_done && !entry_pend_ff && st_ff == fsps_pkg::FSPS_RUN) begin
            if ((cmd_ff == fsps_pkg::CMD_VERIFY_BLK ||
                 cmd_ff == fsps_pkg::CMD_VERIFY_BYTE) && !i_flash_verify_ok) begin
               status_ff[fsps_pkg::ERR_VERIFY] <= 1'b1;
            end
            if (cmd_ff == fsps_pkg::CMD_BLANK && !i_flash_blank_ok) begin
               status_ff[fsps_pkg::ERR_VERIFY] <= 1'b1;
            end
         end
      end
   end

   // ------------------------------------------------------------------------
   // Command, address and data registers
   // ------------------------------------------------------------------------
   // Writable only while the sequencer is idle
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cmd_ff <= fsps_pkg::CMD_RST;
         ptr_l_ff <= 8'h0;
         ptr_h_ff <= 8'h0;
         cmp_l_ff <= 8'h0;
         cmp_h_ff <= 8'h0;
         wbuf_ff <= 8'h0;
      end else if (i_wr && st_ff == fsps_pkg::FSPS_IDLE) begin
         unique case (i_addr)
            fsps_pkg::ADDR_CMD: cmd_ff <= i_wdata[2:0];
            fsps_pkg::ADDR_PTR_L: ptr_l_ff <= i_wdata;
            fsps_pkg::ADDR_PTR_H: ptr_h_ff <= i_wdata;
            fsps_pkg::ADDR_CMP_L: cmp_l_ff <= i_wdata;
            fsps_pkg::ADDR_CMP_H: cmp_h_ff <= i_wdata;
            fsps_pkg::ADDR_WBUF: wbuf_ff <= i_wdata;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------------------
   // Operation timing
   // ------------------------------------------------------------------------
   // Protected block: pointer block number at or below the protect setting
   assign prot_hit = (cmd_ff == fsps_pkg::CMD_ERASE ||
                      cmd_ff == fsps_pkg::CMD_WRITE) &&
                     (ptr_h_ff[3:0] <= {1'b0, prot_ff[2:0]}) &&
                     (prot_ff[4:3] != 2'b11);

   // HALT in self programming mode starts an operation, never standby
   assign start_op = i_halt && mode_ff && st_ff == fsps_pkg::FSPS_IDLE;

   // Duration per command; verify 2 takes one byte time per byte in range
   always_comb begin
      load_cyc = 17'(fsps_pkg::CYC_WRITE);
      if (entry_pend_ff) begin
         load_cyc = 17'(fsps_pkg::CYC_ENTRY);
      end else if (prot_hit) begin
         load_cyc = 17'(fsps_pkg::ENTRY_EXTRA_CYC);
      end else begin
         unique case (cmd_ff)
            fsps_pkg::CMD_VERIFY_BLK: load_cyc = 17'(fsps_pkg::CYC_VERIFY_BLK);
            fsps_pkg::CMD_VERIFY_BYTE: load_cyc = 17'(fsps_pkg::CYC_VERIFY_BYTE *
               (int'(cmp_l_ff - ptr_l_ff) + 1));
            fsps_pkg::CMD_ERASE: load_cyc = 17'(fsps_pkg::CYC_ERASE);
            fsps_pkg::CMD_BLANK: load_cyc = 17'(fsps_pkg::CYC_BLANK);
            fsps_pkg::CMD_WRITE: load_cyc = 17'(fsps_pkg::CYC_WRITE);
            default: load_cyc = 17'(fsps_pkg::ENTRY_EXTRA_CYC);
         endcase
      end
   end

   fsps_timer u_timer (
      .i_ref_clk(i_ref_clk),
      .i_resetn(i_resetn),
      .i_start(start_op),
      .i_cycles(load_cyc),
      .o_done(timer_done)
   );

   // First HALT after entering the mode is the settle wait only
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         entry_pend_ff <= 1'b0;
      end else if (mode_wr_ok && i_wdata[fsps_pkg::MODE_BIT] && !mode_ff) begin
         entry_pend_ff <= 1'b1;
      end else if (timer_done) begin
         entry_pend_ff <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // HALT sequencer
   // ------------------------------------------------------------------------
   // Busy from HALT to the end, then a single wake pulse
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_ff <= fsps_pkg::FSPS_IDLE;
      end else begin
         unique case (st_ff)
            fsps_pkg::FSPS_IDLE: if (start_op) st_ff <= fsps_pkg::FSPS_RUN;
            fsps_pkg::FSPS_RUN: if (timer_done) st_ff <= fsps_pkg::FSPS_WAKE;
            fsps_pkg::FSPS_WAKE: st_ff <= fsps_pkg::FSPS_IDLE;
            default: st_ff <= fsps_pkg::FSPS_IDLE;
         endcase
      end
   end

   // Core-facing controls, all registered
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_busy <= 1'b0;
         o_wake <= 1'b0;
         o_standby <= 1'b0;
         o_irq_block <= 1'b0;
         o_flash_start <= 1'b0;
      end else begin
         o_busy <= start_op ||
                   (st_ff == fsps_pkg::FSPS_RUN && !timer_done);
         o_wake <= st_ff == fsps_pkg::FSPS_RUN && timer_done;
         o_standby <= i_halt && !mode_ff && st_ff == fsps_pkg::FSPS_IDLE;
         o_irq_block <= mode_ff;
         o_flash_start <= start_op && !entry_pend_ff && !prot_hit;
      end
   end

   // Operation parameters to the flash array
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_flash_cmd <= 3'h0;
         o_flash_addr <= 16'h0;
         o_flash_cmp <= 16'h0;
         o_flash_data <= 8'h0;
      end else if (start_op) begin
         o_flash_cmd <= cmd_ff;
         o_flash_addr <= {ptr_h_ff, ptr_l_ff};
         o_flash_cmp <= {cmp_h_ff, cmp_l_ff};
         o_flash_data <= (cmd_ff == fsps_pkg::CMD_ERASE) ?
                         fsps_pkg::BLANK_VALUE : wbuf_ff;
      end
   end

   // ------------------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------------------
   always_comb begin
      nxt_rdata = 8'h0;
      unique case (i_addr)
         fsps_pkg::ADDR_STATUS: nxt_rdata = {5'h0, status_ff};
         fsps_pkg::ADDR_MODE: nxt_rdata = {1'b0, prot_ff, 1'b0, mode_ff};
         fsps_pkg::ADDR_CMD: nxt_rdata = {5'h0, cmd_ff};
         fsps_pkg::ADDR_PTR_L: nxt_rdata = ptr_l_ff;
         fsps_pkg::ADDR_PTR_H: nxt_rdata = ptr_h_ff;
         fsps_pkg::ADDR_CMP_L: nxt_rdata = cmp_l_ff;
         fsps_pkg::ADDR_CMP_H: nxt_rdata = cmp_h_ff;
         fsps_pkg::ADDR_WBUF: nxt_rdata = wbuf_ff;
         default: nxt_rdata = 8'h0;
      endcase
   end

   // Read data is registered, valid the cycle after i_rd
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= 8'h0;
      end else if (i_rd) begin
         o_rdata <= nxt_rdata;
      end
   end
endmodule // fsps_sequencer
`default_nettype wire

// ### logic/fsps_timer.sv
// Down counter that times one flash operation
`timescale 1ns/1ps
`default_nettype none
module fsps_timer (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_start,
   input wire logic [16:0] i_cycles,
   output logic o_done
);
   logic [16:0] cnt_ff;
   logic run_ff;

   // Count down from the load value, pulse done at the last cycle
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_ff <= 17'h0;
         run_ff <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            cnt_ff <= i_cycles;
            run_ff <= 1'b1;
         end else if (run_ff) begin
            if (cnt_ff <= 17'h2) begin
               run_ff <= 1'b0;
               o_done <= 1'b1;
            end
            cnt_ff <= cnt_ff - 17'h1;
         end
      end
   end
endmodule // fsps_timer
`default_nettype wire

// ### tb/fsps_cpu_model.sv
// Behavioural CPU core: stores, loads and HALT
`timescale 1ns/1ps
`default_nettype none
module fsps_cpu_model (
   input wire logic i_ref_clk,
   input wire logic i_wake,
   output logic o_wr,
   output logic o_rd,
   output logic [15:0] o_addr,
   output logic [7:0] o_wdata,
   output logic o_halt
);
   // Idle bus at time zero
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 16'h0000;
      o_wdata = 8'h00;
      o_halt = 1'b0;
   end
   // Launch one access at the falling edge, held over the taking edge
   task automatic access(input logic w, input logic [15:0] a,
         input logic [7:0] d);
      @(negedge i_ref_clk);
      o_wr = w;
      o_rd = !w;
      o_addr = a;
      o_wdata = d;
      @(posedge i_ref_clk);
   endtask
   // Release the bus; lines show no stale value
   task automatic idle();
      @(negedge i_ref_clk);
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = ~o_addr;
      o_wdata = ~o_wdata;
   endtask
   // Key, value, inverse, value as consecutive stores
   task automatic unlock(input logic [7:0] v, input logic [7:0] x);
      access(1'b1, fsps_pkg::ADDR_UNLOCK, fsps_pkg::UNLOCK_KEY);
      access(1'b1, fsps_pkg::ADDR_MODE, v);
      access(1'b1, fsps_pkg::ADDR_MODE, x);
      access(1'b1, fsps_pkg::ADDR_MODE, v);
      idle();
   endtask
   // Core executes nothing until woken or the limit runs out
   task automatic halt(input int lim);
      int n;
      n = 0;
      @(negedge i_ref_clk);
      o_halt = 1'b1;
      while (i_wake !== 1'b1 && n < lim) begin
         @(posedge i_ref_clk);
         n++;
      end
      @(negedge i_ref_clk);
      o_halt = 1'b0;
   endtask
endmodule // fsps_cpu_model
`default_nettype wire

// ### tb/fsps_seq_properties.sv
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module fsps_seq_properties (
   input wire logic i_ref_clk,
   input wire logic i_resetn,
   input wire logic i_wr,
   input wire logic [15:0] i_addr,
   input wire logic i_halt,
   input wire logic o_busy,
   input wire logic o_wake,
   input wire logic o_standby,
   input wire logic o_irq_block,
   input wire logic o_flash_start,
   input wire logic [2:0] o_flash_cmd,
   input wire logic [7:0] o_flash_data
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);
   // HALT in programming mode stalls the core on the next cycle
   property p_halt_stall;
      $rose(i_halt) && o_irq_block && !o_busy |=> o_busy;
   endproperty
   a_halt_stall: assert property (p_halt_stall)
      else $error("halt did not stall the core");
   // A launch only follows a HALT in programming mode
   property p_start_cause;
      o_flash_start |-> $past(i_halt) && o_irq_block && o_busy;
   endproperty
   a_start_cause: assert property (p_start_cause)
      else $error("flash launch without halt");
   // Wake ends a stall that really ran
   property p_wake_end;
      o_wake |-> !o_busy && $past(o_busy);
   endproperty
   a_wake_end: assert property (p_wake_end)
      else $error("wake without preceding stall");
   // Wake is a single pulse
   property p_wake_once;
      o_wake |=> !o_wake;
   endproperty
   a_wake_once: assert property (p_wake_once)
      else $error("wake longer than one cycle");
   // Interrupts stay held off while a command runs
   property p_irq_hold;
      o_busy |-> o_irq_block;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupts open during command");
   // Standby only in normal mode
   property p_standby;
      o_standby |-> !o_irq_block && !o_busy;
   endproperty
   a_standby: assert property (p_standby)
      else $error("standby in programming mode");
   // Erase launches with the blank pattern
   property p_erase_blank;
      o_flash_start && o_flash_cmd == fsps_pkg::CMD_ERASE
         |-> o_flash_data == fsps_pkg::BLANK_VALUE;
   endproperty
   a_erase_blank: assert property (p_erase_blank)
      else $error("erase data not blank");
   // Mode turns on only after a store to the mode register
   property p_mode_guard;
      $rose(o_irq_block)
         |-> $past(i_wr, 2) && $past(i_addr, 2) == fsps_pkg::ADDR_MODE;
   endproperty
   a_mode_guard: assert property (p_mode_guard)
      else $error("mode set without mode store");
endmodule // fsps_seq_properties
bind fsps_sequencer fsps_seq_properties u_props (
   .i_ref_clk(i_ref_clk),
   .i_resetn(i_resetn),
   .i_wr(i_wr),
   .i_addr(i_addr),
   .i_halt(i_halt),
   .o_busy(o_busy),
   .o_wake(o_wake),
   .o_standby(o_standby),
   .o_irq_block(o_irq_block),
   .o_flash_start(o_flash_start),
   .o_flash_cmd(o_flash_cmd),
   .o_flash_data(o_flash_data)
);
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the flash self programming sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [4:0] prot = 5'h18;
   logic ver_ok = 1'b1;
   logic blank_ok = 1'b1;
   logic wr, rd, halt, busy, wake, standby, irq_block, fstart;
   logic [15:0] addr, faddr, fcmp;
   logic [7:0] wdata, rdata, fdata, r0, r1;
   logic [2:0] fcmd;
   logic rd_d = 1'b0;
   logic halt_d = 1'b0;
   logic start_seen = 1'b0;
   logic standby_seen = 1'b0;
   int lat = 0;
   int n_mismatch = 0;
   int check_count = 0;
   int seed = 74083;
   logic [7:0] q_data[$];
   int q_lat[$];
   // 10 MHz core clock, above the 1 MHz floor
   always #50 clk = ~clk;
   fsps_sequencer u_dut (.i_ref_clk(clk), .i_resetn(resetn), .i_wr(wr),
      .i_rd(rd), .i_addr(addr), .i_wdata(wdata), .i_halt(halt),
      .i_protect_byte(prot), .i_flash_verify_ok(ver_ok),
      .i_flash_blank_ok(blank_ok), .o_rdata(rdata), .o_busy(busy),
      .o_wake(wake), .o_standby(standby), .o_irq_block(irq_block),
      .o_flash_start(fstart), .o_flash_cmd(fcmd), .o_flash_addr(faddr),
      .o_flash_cmp(fcmp), .o_flash_data(fdata));
   fsps_cpu_model u_cpu (.i_ref_clk(clk), .i_wake(wake), .o_wr(wr),
      .o_rd(rd), .o_addr(addr), .o_wdata(wdata), .o_halt(halt));
   // Compare tasks for values and for stall lengths
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_lat(input int got, input int exp);
      check_count++;
      if (got < exp - 1 || got > exp + 1) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      // A note never answered means a missing read or wake
      if (q_lat.size() != 0 || q_data.size() != 0) n_mismatch++;
      if (n_mismatch == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Bus and HALT wrappers; ld and op note the expected answer
   task automatic st(input logic [15:0] a, input logic [7:0] d);
      u_cpu.access(1'b1, a, d);
      u_cpu.idle();
   endtask
   task automatic ld(input logic [15:0] a, input logic [7:0] e);
      q_data.push_back(e);
      u_cpu.access(1'b0, a, 8'h00);
      u_cpu.idle();
   endtask
   task automatic op(input int cyc);
      q_lat.push_back(cyc);
      u_cpu.halt(cyc + 20);
   endtask
   task automatic do_reset(input logic [4:0] p);
      @(negedge clk);
      resetn = 1'b0;
      prot = p;
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
   endtask
   task automatic mode_set(input logic [7:0] v);
      st(fsps_pkg::ADDR_CMD, 8'h00);
      u_cpu.unlock(v, ~v);
   endtask
   task automatic enter();
      mode_set(8'h01);
      @(negedge clk);
      op(fsps_pkg::CYC_ENTRY + 1);
      repeat (80) @(negedge clk);
   endtask
   // Watcher pairs each answer with the oldest note
   always @(posedge clk) begin
      if (rd_d) chk(rdata, q_data.pop_front());
      rd_d = rd;
      lat = (halt && !halt_d) ? 0 : lat + 1;
      halt_d = halt;
      if (wake === 1'b1 && q_lat.size() > 0) chk_lat(lat, q_lat.pop_front());
      if (fstart === 1'b1) start_seen = 1'b1;
      if (standby === 1'b1) standby_seen = 1'b1;
   end
   // Watchdog against a hang
   initial begin
      #5_000_000;
      n_mismatch++;
      report_and_stop();
   end
   // Main sequence
   initial begin
      r0 = $random(seed);
      do_reset({2'b11, r0[2:0]});
      ld(fsps_pkg::ADDR_MODE, {1'b0, prot, 2'b00});
      ld(fsps_pkg::ADDR_STATUS, 8'h00);
      st(fsps_pkg::ADDR_MODE, 8'h01);
      ld(fsps_pkg::ADDR_MODE, {1'b0, prot, 2'b00});
      ld(fsps_pkg::ADDR_STATUS, 8'h01);
      st(fsps_pkg::ADDR_STATUS, 8'h00);
      ld(fsps_pkg::ADDR_STATUS, 8'h00);
      ld(16'hffaf, 8'h00);
      u_cpu.unlock(8'h01, 8'h01);
      ld(fsps_pkg::ADDR_MODE, {1'b0, prot, 2'b00});
      ld(fsps_pkg::ADDR_STATUS, 8'h01);
      st(fsps_pkg::ADDR_STATUS, 8'h00);
      u_cpu.halt(6);
      chk(standby_seen, 1'b1);
      chk(start_seen, 1'b0);
      enter();
      ld(fsps_pkg::ADDR_MODE, {1'b0, prot, 2'b01});
      chk(irq_block, 1'b1);
      r0 = $random(seed);
      r1 = $random(seed);
      st(fsps_pkg::ADDR_PTR_H, 8'h05);
      st(fsps_pkg::ADDR_PTR_L, r0);
      st(fsps_pkg::ADDR_WBUF, r1);
      st(fsps_pkg::ADDR_CMD, {5'h00, fsps_pkg::CMD_WRITE});
      op(fsps_pkg::CYC_WRITE + 1);
      chk({fcmd, faddr, fdata}, {fsps_pkg::CMD_WRITE, 8'h05, r0, r1});
      blank_ok = 1'b0;
      st(fsps_pkg::ADDR_CMD, {5'h00, fsps_pkg::CMD_BLANK});
      op(fsps_pkg::CYC_BLANK + 1);
      ld(fsps_pkg::ADDR_STATUS, 8'h02);
      blank_ok = 1'b1;
      st(fsps_pkg::ADDR_STATUS, 8'h00);
      st(fsps_pkg::ADDR_PTR_L, 8'h10);
      st(fsps_pkg::ADDR_CMP_H, 8'h05);
      st(fsps_pkg::ADDR_CMP_L, 8'h13);
      st(fsps_pkg::ADDR_CMD, {5'h00, fsps_pkg::CMD_VERIFY_BYTE});
      ver_ok = 1'b0;
      op(fsps_pkg::CYC_VERIFY_BYTE * 4 + 1);
      chk(fcmp, 16'h0513);
      ld(fsps_pkg::ADDR_STATUS, 8'h02);
      ver_ok = 1'b1;
      st(fsps_pkg::ADDR_STATUS, 8'h00);
      // Long commands: watch the launch, then cut short by reset
      for (int i = 0; i < 2; i++) begin
         st(fsps_pkg::ADDR_CMD, i ? {5'h00, fsps_pkg::CMD_VERIFY_BLK}
            : {5'h00, fsps_pkg::CMD_ERASE});
         start_seen = 1'b0;
         u_cpu.halt(20);
         chk(start_seen, 1'b1);
         chk(fcmd, i ? fsps_pkg::CMD_VERIFY_BLK : fsps_pkg::CMD_ERASE);
         if (i == 0) chk(fdata, fsps_pkg::BLANK_VALUE);
         do_reset(i ? 5'h03 : prot);
         enter();
      end
      st(fsps_pkg::ADDR_PTR_H, 8'h02);
      st(fsps_pkg::ADDR_CMD, {5'h00, fsps_pkg::CMD_ERASE});
      start_seen = 1'b0;
      op(3);
      chk(start_seen, 1'b0);
      ld(fsps_pkg::ADDR_STATUS, 8'h04);
      st(fsps_pkg::ADDR_PTR_H, 8'h05);
      st(fsps_pkg::ADDR_CMD, {5'h00, fsps_pkg::CMD_WRITE});
      op(fsps_pkg::CYC_WRITE + 1);
      chk(start_seen, 1'b1);
      mode_set(8'h00);
      ld(fsps_pkg::ADDR_MODE, {1'b0, prot, 2'b00});
      chk(irq_block, 1'b0);
      repeat (4) @(negedge clk);
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
